/* File: eil_defines.svh */
`ifndef EIL_DEFINES_SVH
`define EIL_DEFINES_SVH

// ----------------------------------------
// status and control field positions
// ----------------------------------------
`define EIL_BIT_MODE 0
`define EIL_BIT_GATE 1
`define EIL_BIT_ACK 2
`define EIL_BIT_PEND 3
`define EIL_SCR_W 8

// ----------------------------------------
// reset values and vector locations
// ----------------------------------------
`define EIL_RST_MODE 1'h0
`define EIL_RST_GATE 1'h0
`define EIL_RST_LATCH 1'h0
`define EIL_VEC_HI 16'hFFFA
`define EIL_VEC_LO 16'hFFFB

`endif

/* File: eil_pkg.sv */
package eil_pkg;

   typedef struct packed {
      logic wr;
      logic [7:0] wdata;
   } eil_wr_t;

   typedef struct packed {
      logic vec_fetch;
      logic in_break;
      logic break_clear_enable;
   } eil_cpu_t;

   typedef enum logic [1:0] {
      EIL_IDLE = 2'b00,
      EIL_PEND = 2'b01,
      EIL_HELD = 2'b10
   } eil_state_t;

endpackage : eil_pkg

/* File: eil_sync.sv */
`timescale 1ns/1ps
module eil_sync
(
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic CE,
   input wire logic d,
   output logic q
);
   logic stage1;
   logic stage2;
   logic next_stage1;
   logic next_stage2;

   // ----------------------------------------
   // two-flop synchroniser, keeps sampling in reset
   // ----------------------------------------
   always_comb
   begin
      next_stage1 = stage1;
      next_stage2 = stage2;
      if (RESET)
      begin
         next_stage1 = d;
         next_stage2 = stage1;
      end
      else if (CE)
      begin
         next_stage1 = d;
         next_stage2 = stage1;
      end
   end

   always_ff @(posedge REF_CLK)
   begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
   end

   assign q = stage2;
endmodule : eil_sync

/* File: eil_top.sv */
`timescale 1ns/1ps
`include "eil_defines.svh"
module eil_top
(
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic CE,
   input wire logic IRQ_PIN_N,
   input eil_pkg::eil_wr_t SCR_WR,
   input eil_pkg::eil_cpu_t CPU,
   output logic [7:0] SCR_RDATA,
   output logic IRQ_REQ,
   output logic [15:0] VEC_ADDR_HI,
   output logic [15:0] VEC_ADDR_LO,
   output logic PIN_LEVEL
);
   logic pin_sync;
   logic pin_prev;
   logic next_pin_prev;
   logic mode;
   logic next_mode;
   logic gate;
   logic next_gate;
   logic latch;
   logic next_latch;
   logic acked;
   logic next_acked;
   logic fall;
   logic ack;
   logic sw_ack;
   logic [7:0] next_rdata;

   // ----------------------------------------
   // pin input
   // ----------------------------------------
   eil_sync u_sync
   (
      .REF_CLK(REF_CLK),
      .RESET(RESET),
      .CE(CE),
      .d(IRQ_PIN_N),
      .q(pin_sync)
   );

   // ----------------------------------------
   // edge detect and acknowledge decode
   // ----------------------------------------
   always_comb
   begin
      fall = pin_prev & ~pin_sync;
      sw_ack = SCR_WR.wr & SCR_WR.wdata[`EIL_BIT_ACK];
      if (CPU.in_break & ~CPU.break_clear_enable)
      begin
         sw_ack = 1'h0;
      end
      ack = CPU.vec_fetch | sw_ack;
   end

   // ----------------------------------------
   // control bits and latch
   // ----------------------------------------
   always_comb
   begin
      next_pin_prev = pin_prev;
      next_mode = mode;
      next_gate = gate;
      next_latch = latch;
      next_acked = acked;
      if (RESET)
      begin
         next_pin_prev = pin_sync;
         next_mode = `EIL_RST_MODE;
         next_gate = `EIL_RST_GATE;
         next_latch = `EIL_RST_LATCH;
         next_acked = 1'h0;
      end
      else if (CE)
      begin
         next_pin_prev = pin_sync;
         next_acked = acked & mode;
         if (SCR_WR.wr)
         begin
            next_mode = SCR_WR.wdata[`EIL_BIT_MODE];
            next_gate = SCR_WR.wdata[`EIL_BIT_GATE];
         end
         if (ack)
         begin
            next_latch = 1'h0;
            next_acked = mode;
         end
         if (mode & acked & pin_sync)
         begin
            next_latch = 1'h0;
            next_acked = 1'h0;
         end
         if (mode & ~pin_sync)
         begin
            next_latch = 1'h1;
         end
         if (fall)
         begin
            next_latch = 1'h1;
            next_acked = 1'h0;
         end
      end
   end

   always_ff @(posedge REF_CLK)
   begin
      pin_prev <= next_pin_prev;
      mode <= next_mode;
      gate <= next_gate;
      latch <= next_latch;
      acked <= next_acked;
   end

   // ----------------------------------------
   // read data register
   // ----------------------------------------
   always_comb
   begin
      next_rdata = SCR_RDATA;
      if (RESET)
      begin
         next_rdata = 8'h00;
      end
      else if (CE)
      begin
         next_rdata = 8'h00;
         next_rdata[`EIL_BIT_MODE] = next_mode;
         next_rdata[`EIL_BIT_GATE] = next_gate;
         next_rdata[`EIL_BIT_PEND] = next_latch;
      end
   end

   always_ff @(posedge REF_CLK)
   begin
      SCR_RDATA <= next_rdata;
   end

   assign IRQ_REQ = latch & ~gate;
   assign VEC_ADDR_HI = `EIL_VEC_HI;
   assign VEC_ADDR_LO = `EIL_VEC_LO;
   assign PIN_LEVEL = pin_sync;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RESET);

   edge_sets_a: assert property (CE && fall |=> latch)
      else $error("falling edge did not set latch");
   edge_ack_clear_a: assert property (CE && ack && !fall && !mode |=> !latch)
      else $error("edge mode acknowledge did not clear");
   edge_hold_a: assert property (latch && !ack && !mode && CE |=> latch)
      else $error("latch dropped without acknowledge");
   level_pend_a: assert property (CE && mode && !pin_sync |=> latch)
      else $error("low level not pending");
   gate_blocks_a: assert property (gate |-> !IRQ_REQ)
      else $error("gated request forwarded");
   pend_flag_a: assert property (CE |=> SCR_RDATA[`EIL_BIT_PEND] == latch)
      else $error("pending flag wrong");
   ack_reads_zero_a: assert property (SCR_RDATA[`EIL_BIT_ACK] == 1'b0)
      else $error("acknowledge bit read nonzero");
   break_protect_a: assert property (CE && latch && CPU.in_break && !CPU.break_clear_enable
      && !CPU.vec_fetch && !(mode && acked && pin_sync) |=> latch)
      else $error("acknowledge acted during break");
   reset_clear_a: assert property (@(posedge REF_CLK) disable iff (1'b0)
      RESET |=> !latch && !mode)
      else $error("reset did not clear");
   level_release_a: assert property (CE && mode && acked && pin_sync |=> !latch)
      else $error("level request not released");

   edge_seen_c: cover property (CE && fall);
   level_hold_c: cover property (mode && ack && !pin_sync);
   gated_pend_c: cover property (gate && latch);
   level_release_c: cover property (mode && acked && pin_sync);
   break_block_c: cover property (CPU.in_break && SCR_WR.wr && latch);
endmodule : eil_top

/* File: eil_cpu_model.sv */
`timescale 1ns/1ps
module eil_cpu_model
(
   input wire logic REF_CLK,
   input wire logic IRQ_REQ,
   input wire logic EN,
   output logic VEC_FETCH
);
   // ----
   // vector fetch on unmasked request
   // ----
   initial VEC_FETCH = 1'h0;
   always @(posedge REF_CLK)
   begin
      VEC_FETCH <= EN & IRQ_REQ & ~VEC_FETCH;
   end
endmodule : eil_cpu_model

/* File: external_interrupt_latch_tb.sv */
`timescale 1ns/1ps
module external_interrupt_latch_tb;
   // ----
   // bench
   // ----
   logic clk = 0, rst = 1, pin_n = 1, fen = 0, brk = 0, bce = 0, ce = 1, fetch, req, lvl;
   logic [7:0] rd;
   logic [15:0] vh, vl;
   eil_pkg::eil_wr_t wr = '0;
   eil_pkg::eil_cpu_t cpu;
   int num_errors = 0, tests_run = 0, cyc = 0;
   assign cpu = {fetch, brk, bce};
   always #5 clk = ~clk;
   eil_cpu_model cm (.REF_CLK(clk), .IRQ_REQ(req), .EN(fen), .VEC_FETCH(fetch));
   eil_top dut (.REF_CLK(clk), .RESET(rst), .CE(ce), .IRQ_PIN_N(pin_n), .SCR_WR(wr),
      .CPU(cpu), .SCR_RDATA(rd), .IRQ_REQ(req), .VEC_ADDR_HI(vh), .VEC_ADDR_LO(vl),
      .PIN_LEVEL(lvl));
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      tests_run++;
      if (g !== e)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic st(string n, logic [15:0] e);
      chk(n, e, {rd, 7'h00, req});
   endtask : st
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic put(logic [7:0] d);
      @(posedge clk);
      wr <= '{1'h1, d};
      @(posedge clk);
      wr <= '0;
      tick(2);
   endtask : put
   task automatic drive(logic v);
      @(posedge clk);
      pin_n <= v;
      tick(4);
      chk("pin level", {15'h0000, v}, {15'h0000, lvl});
   endtask : drive
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         num_errors++;
         summarize();
      end
   end
   initial
   begin
      tick(16);
      @(posedge clk);
      rst <= 1'h0;
      tick(2);
      st("after reset", 16'h0000);
      chk("vector hi", 16'hFFFA, vh);
      chk("vector lo", 16'hFFFB, vl);
      put(8'h02);
      drive(1'h0);
      st("masked", 16'h0A00);
      put(8'h06);
      st("ack pin low", 16'h0200);
      drive(1'h1);
      put(8'h00);
      drive(1'h0);
      drive(1'h1);
      st("edge hold", 16'h0801);
      put(8'h04);
      st("sw ack", 16'h0000);
      drive(1'h0);
      st("fresh edge", 16'h0801);
      @(posedge clk);
      ce <= 1'h0;
      put(8'h04);
      st("frozen", 16'h0801);
      @(posedge clk);
      ce <= 1'h1;
      @(posedge clk);
      fen <= 1'h1;
      tick(3);
      st("fetched", 16'h0000);
      @(posedge clk);
      fen <= 1'h0;
      drive(1'h1);
      put(8'h01);
      drive(1'h0);
      st("level", 16'h0901);
      put(8'h07);
      st("level ack low", 16'h0B00);
      drive(1'h1);
      st("level cleared", 16'h0300);
      put(8'h00);
      drive(1'h0);
      @(posedge clk);
      brk <= 1'h1;
      put(8'h04);
      st("break hold", 16'h0801);
      @(posedge clk);
      bce <= 1'h1;
      put(8'h04);
      st("break ack", 16'h0000);
      @(posedge clk);
      brk <= 1'h0;
      bce <= 1'h0;
      drive(1'h1);
      put(8'h01);
      drive(1'h0);
      @(posedge clk);
      rst <= 1'h1;
      tick(2);
      rst <= 1'h0;
      tick(4);
      st("reset pin low", 16'h0000);
      summarize();
   end
endmodule : external_interrupt_latch_tb
